/* asp_pkg.sv */
/*
 Shared constants and types for the serial audio master port.
 Assumes a 125 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package asp_pkg;
   // System clock and link rates.
   localparam int CLK_HZ = 125_000_000;
   localparam int RATE_8K_HZ = 8000;
   localparam int RATE_16K_HZ = 16000;
   localparam int FRAME_SLOTS = 32;
   localparam int WORD_BITS = 16;
   localparam int MCLK_13_HZ = 13_000_000;
   localparam int MCLK_26_HZ = 26_000_000;
   // Rate generators add a step each cycle and tick when passing CLK_HZ.
   localparam logic [27:0] ACC_MOD = 28'(CLK_HZ);
   localparam logic [27:0] BCLK_STEP_8K = 28'(2 * FRAME_SLOTS * RATE_8K_HZ);
   localparam logic [27:0] BCLK_STEP_16K = 28'(2 * FRAME_SLOTS * RATE_16K_HZ);
   localparam logic [27:0] MCLK_STEP_13 = 28'(2 * MCLK_13_HZ);
   localparam logic [27:0] MCLK_STEP_26 = 28'(2 * MCLK_26_HZ);
   // Frame slot positions.
   localparam logic [4:0] FIRST_SLOT = 5'h00;
   localparam logic [4:0] LAST_DATA_SLOT = 5'(WORD_BITS - 1);
   localparam logic [4:0] LAST_SLOT = 5'(FRAME_SLOTS - 1);
   localparam logic [4:0] PCM_SYNC1 = 5'h01;
   localparam logic [4:0] PCM_SYNC2 = 5'h02;
   localparam logic [4:0] NORM_SYNC = 5'h10;
   // Register map, byte addresses.
   localparam int AXI_AW = 8;
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_TXDATA = 8'h04;
   localparam logic [7:0] OFF_RXDATA = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0c;
   // Control fields.
   localparam int CB_EN = 0;
   localparam int CB_NORMAL = 1;
   localparam int CB_RATE16 = 2;
   localparam int CB_SYNC2 = 3;
   localparam int CB_MCLK_EN = 4;
   localparam int CB_MCLK26 = 5;
   localparam int CB_DIS_TXD = 8;
   localparam int CB_DIS_RXD = 9;
   localparam int CB_DIS_CLK = 10;
   localparam int CB_DIS_WA = 11;
   localparam int CB_DIS_MCLK = 12;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] CTRL_MASK = 32'h0000_1f3f;
   localparam logic [15:0] TXDATA_RST = 16'h0000;
   // Status fields.
   localparam int SB_RXNEW = 0;
   localparam int SB_TXTAKEN = 1;
   localparam int SB_SLOT = 8;
   // Bus responses.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // One pad: driven level, output enable, pull-down enable.
   typedef struct packed {
      logic pullDn;
      logic oe;
      logic out;
   } asp_pin_t;

   typedef enum logic [1:0] {WS_COLLECT = 2'b01, WS_RESP = 2'b10} asp_wst_t;
   typedef enum logic [1:0] {RS_IDLE = 2'b01, RS_DATA = 2'b10} asp_rst_t;
endpackage

/* asp_sync3.sv */
/*
 Three-stage input synchroniser with agreement filter.
 Assumes an asynchronous pin level on din.
*/
`timescale 1ns/1ps
module asp_sync3
   import asp_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Level in and filtered level out
   input wire logic din,
   output logic dout
);
   logic s1_r, s2_r, s3_r, dout_r;
   logic dout_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // The output only follows once the last two stages agree.
   always_comb begin
      dout_nxt = (s2_r == s3_r) ? s3_r : dout_r;
   end

   // The first stage feeds only the second to keep metastability contained.
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         dout_r <= 1'b0;
      end else begin
         s1_r <= din;
         s2_r <= s1_r;
         s3_r <= s2_r;
         dout_r <= dout_nxt;
      end
   end

   assign dout = dout_r;
endmodule

/* asp_nco.sv */
/*
 Fractional rate generator giving one-cycle tick pulses.
 Assumes step is below ACC_MOD; the average tick rate is step / ACC_MOD.
*/
`timescale 1ns/1ps
module asp_nco
   import asp_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Rate control
   input wire logic en,
   input wire logic [27:0] step,
   // One-cycle pulse
   output logic tick
);
   logic [27:0] acc_r, acc_nxt;
   logic [28:0] sum;

   ////////////////////////////////////////////////////////////////////////////
   // Accumulate exactly so the long-term rate has no drift, at the cost of
   // one cycle of jitter on individual ticks.
   always_comb begin
      sum = {1'b0, acc_r} + {1'b0, step};
      tick = 1'b0;
      acc_nxt = sum[27:0];
      if (!en) begin
         acc_nxt = '0;
      end else if (sum >= {1'b0, ACC_MOD}) begin
         tick = 1'b1;
         acc_nxt = 28'(sum - {1'b0, ACC_MOD});
      end
   end

   // Accumulator register.
   always_ff @(posedge clk) begin
      if (rst) begin
         acc_r <= '0;
      end else begin
         acc_r <= acc_nxt;
      end
   end
endmodule

/* asp_master_port.sv */
/*
 Serial audio master port with an AXI4-Lite register slave.
 Assumes one 125 MHz clock, synchronous reset, and an external codec that
 launches its data on the falling bit-clock edge.
*/
// Functional notes
// R1: Four lines: data out, data in, bit clock out, word-align out.
// R2: Configuration selects short-sync PCM or long-sync normal framing.
// R3: PCM word-align high 1 or 2 bit clocks, low rest of 32.
// R4: Normal mode word-align high 16 clocks, then low 16 clocks.
// R5: Port is master only; it always makes bit clock and word-align.
// R6: Sample rate 8 or 16 kHz equals word-align frequency.
// R7: Bit clock is 32 times sample rate; frame is 32 clocks.
// R8: Samples are 16-bit linear mono, one word each way per frame.
// R9: Samples are two's-complement signed in both directions.
// R10: Words are shifted most significant bit first both ways.
// R11: No received audio is mixed into transmitted audio.
// R12: Optional 13 or 26 MHz master clock on a dedicated pin.
// R13: A disabled pin is tri-stated with its pull-down enabled.
// R14: Data launches on falling bit clock, sampled on rising edge.
// R15: Word fills first 16 slots; rest drive zero, input ignored.
`timescale 1ns/1ps
module asp_master_port
   import asp_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // AXI4-Lite write address and data
   input wire logic [AXI_AW-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // AXI4-Lite write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read
   input wire logic [AXI_AW-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Audio pins
   output asp_pin_t txdPin,
   output asp_pin_t bclkPin,
   output asp_pin_t audioWordAlignOut,
   output asp_pin_t codecMasterClockPin,
   input wire logic rxdIn,
   output logic rxdPullDn
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   // Merge a write into a register under byte strobes.
   function automatic logic [31:0] applyStrb(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return res;
   endfunction

   asp_wst_t ws_r, ws_nxt;
   asp_rst_t rs_r, rs_nxt;
   logic awGot_r, awGot_nxt, wGot_r, wGot_nxt;
   logic [AXI_AW-1:0] wAddr_r, wAddr_nxt;
   logic [31:0] wData_r, wData_nxt;
   logic [3:0] wStrb_r, wStrb_nxt;
   logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt, ctrl_r, ctrl_nxt;
   logic [15:0] txData_r, txData_nxt;
   logic rxNew_r, rxNew_nxt, txTaken_r, txTaken_nxt;
   logic doWrite;
   logic portEn, halfTick, mclkTick, bclkRise, bclkFall, rxSync, rxBit;
   logic bclk_r, bclk_nxt, wa_r, wa_nxt, txd_r, txd_nxt, mclk_r, mclk_nxt;
   logic [4:0] slot_r, slot_nxt, syncLen;
   logic [15:0] txSh_r, txSh_nxt, rxSh_r, rxSh_nxt, rxWord_r, rxWord_nxt;
   logic rxEvt, txEvt;

   ////////////////////////////////////////////////////////////////////////////
   // Bus handshakes depend only on state, so they never loop back on valid.
   assign awready = (ws_r == WS_COLLECT) && !awGot_r;
   assign wready = (ws_r == WS_COLLECT) && !wGot_r;
   assign bvalid = (ws_r == WS_RESP);
   assign bresp = bresp_r;
   assign arready = (rs_r == RS_IDLE);
   assign rvalid = (rs_r == RS_DATA);
   assign rdata = rdata_r;
   assign rresp = rresp_r;
   assign doWrite = (ws_r == WS_COLLECT) && awGot_r && wGot_r;

   // Register file and bus state; address and data may arrive in either order.
   always_comb begin
      ws_nxt = ws_r;
      rs_nxt = rs_r;
      awGot_nxt = awGot_r;
      wGot_nxt = wGot_r;
      wAddr_nxt = wAddr_r;
      wData_nxt = wData_r;
      wStrb_nxt = wStrb_r;
      bresp_nxt = bresp_r;
      rresp_nxt = rresp_r;
      rdata_nxt = rdata_r;
      ctrl_nxt = ctrl_r;
      txData_nxt = txData_r;
      // Hardware events win over a clear in the same cycle.
      rxNew_nxt = rxNew_r;
      txTaken_nxt = txTaken_r;
      case (ws_r)
         WS_COLLECT: begin
            if (awvalid && awready) begin
               awGot_nxt = 1'b1;
               wAddr_nxt = awaddr;
            end
            if (wvalid && wready) begin
               wGot_nxt = 1'b1;
               wData_nxt = wdata;
               wStrb_nxt = wstrb;
            end
            if (doWrite) begin
               awGot_nxt = 1'b0;
               wGot_nxt = 1'b0;
               ws_nxt = WS_RESP;
               bresp_nxt = RESP_OKAY;
               if (wAddr_r == OFF_CTRL) begin
                  ctrl_nxt = applyStrb(ctrl_r, wData_r, wStrb_r) & CTRL_MASK; // R2
               end else if (wAddr_r == OFF_TXDATA) begin
                  txData_nxt = 16'(applyStrb({16'h0000, txData_r}, wData_r, wStrb_r)); // R11
               end else if (wAddr_r == OFF_STATUS) begin
                  if (wStrb_r[0] && wData_r[SB_RXNEW]) begin
                     rxNew_nxt = 1'b0;
                  end
                  if (wStrb_r[0] && wData_r[SB_TXTAKEN]) begin
                     txTaken_nxt = 1'b0;
                  end
               end else if (wAddr_r != OFF_RXDATA) begin
                  bresp_nxt = RESP_SLVERR;
               end
            end
         end
         WS_RESP: begin
            if (bready) begin
               ws_nxt = WS_COLLECT;
            end
         end
         default: ws_nxt = WS_COLLECT;
      endcase
      if (rxEvt) begin
         rxNew_nxt = 1'b1;
      end
      if (txEvt) begin
         txTaken_nxt = 1'b1;
      end
      case (rs_r)
         RS_IDLE: begin
            if (arvalid) begin
               rs_nxt = RS_DATA;
               rresp_nxt = RESP_OKAY;
               rdata_nxt = 32'h0000_0000;
               if (araddr == OFF_CTRL) begin
                  rdata_nxt = ctrl_r;
               end else if (araddr == OFF_TXDATA) begin
                  rdata_nxt = {16'h0000, txData_r};
               end else if (araddr == OFF_RXDATA) begin
                  rdata_nxt = {{16{rxWord_r[15]}}, rxWord_r}; // R9
               end else if (araddr == OFF_STATUS) begin
                  rdata_nxt[SB_RXNEW] = rxNew_r;
                  rdata_nxt[SB_TXTAKEN] = txTaken_r;
                  rdata_nxt[SB_SLOT +: 5] = slot_r;
               end else begin
                  rresp_nxt = RESP_SLVERR;
               end
            end
         end
         RS_DATA: begin
            if (rready) begin
               rs_nxt = RS_IDLE;
            end
         end
         default: rs_nxt = RS_IDLE;
      endcase
   end

   // Bus and register state.
   always_ff @(posedge clk) begin
      if (rst) begin
         ws_r <= WS_COLLECT;
         rs_r <= RS_IDLE;
         awGot_r <= 1'b0;
         wGot_r <= 1'b0;
         wAddr_r <= '0;
         wData_r <= '0;
         wStrb_r <= '0;
         bresp_r <= RESP_OKAY;
         rresp_r <= RESP_OKAY;
         rdata_r <= '0;
         ctrl_r <= CTRL_RST;
         txData_r <= TXDATA_RST;
         rxNew_r <= 1'b0;
         txTaken_r <= 1'b0;
      end else begin
         ws_r <= ws_nxt;
         rs_r <= rs_nxt;
         awGot_r <= awGot_nxt;
         wGot_r <= wGot_nxt;
         wAddr_r <= wAddr_nxt;
         wData_r <= wData_nxt;
         wStrb_r <= wStrb_nxt;
         bresp_r <= bresp_nxt;
         rresp_r <= rresp_nxt;
         rdata_r <= rdata_nxt;
         ctrl_r <= ctrl_nxt;
         txData_r <= txData_nxt;
         rxNew_r <= rxNew_nxt;
         txTaken_r <= txTaken_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Rate generators: half bit-clock ticks and master clock half periods.
   assign portEn = ctrl_r[CB_EN];
   asp_nco uBclkNco (
      .clk(clk),
      .rst(rst),
      .en(portEn),
      .step(ctrl_r[CB_RATE16] ? BCLK_STEP_16K : BCLK_STEP_8K), // R6
      .tick(halfTick)
   );
   asp_nco uMclkNco (
      .clk(clk),
      .rst(rst),
      .en(ctrl_r[CB_MCLK_EN] && !ctrl_r[CB_DIS_MCLK]),
      .step(ctrl_r[CB_MCLK26] ? MCLK_STEP_26 : MCLK_STEP_13), // R12
      .tick(mclkTick)
   );
   asp_sync3 uRxSync (
      .clk(clk),
      .rst(rst),
      .din(rxdIn),
      .dout(rxSync)
   );

   assign bclkRise = halfTick && !bclk_r;
   assign bclkFall = halfTick && bclk_r;
   // A disabled input floats low on its pull-down, so read it as zero.
   assign rxBit = ctrl_r[CB_DIS_RXD] ? 1'b0 : rxSync; // R13
   assign syncLen = ctrl_r[CB_SYNC2] ? PCM_SYNC2 : PCM_SYNC1;

   // Frame engine: one slot per bit clock, 32 slots per frame.
   always_comb begin
      bclk_nxt = bclk_r;
      slot_nxt = slot_r;
      wa_nxt = wa_r;
      txd_nxt = txd_r;
      txSh_nxt = txSh_r;
      rxSh_nxt = rxSh_r;
      rxWord_nxt = rxWord_r;
      mclk_nxt = mclk_r;
      rxEvt = 1'b0;
      txEvt = 1'b0;
      if (!ctrl_r[CB_MCLK_EN] || ctrl_r[CB_DIS_MCLK]) begin
         mclk_nxt = 1'b0;
      end else if (mclkTick) begin
         mclk_nxt = !mclk_r; // R12
      end
      if (!portEn) begin
         // Parked with the clock low so the first fall opens slot 0.
         bclk_nxt = 1'b0; // R5
         slot_nxt = LAST_SLOT;
         wa_nxt = 1'b0;
         txd_nxt = 1'b0;
      end else begin
         if (halfTick) begin
            bclk_nxt = !bclk_r; // R7
         end
         if (bclkFall) begin
            slot_nxt = slot_r + 5'h01; // R7
            if (slot_r == LAST_SLOT) begin
               // Only the written sample is sent; received audio never enters.
               txSh_nxt = txData_r; // R11 R8
               txEvt = 1'b1;
            end else begin
               txSh_nxt = {txSh_r[14:0], 1'b0}; // R10
            end
            txd_nxt = (slot_nxt <= LAST_DATA_SLOT) ? txSh_nxt[15] : 1'b0; // R14 R15
            if (ctrl_r[CB_NORMAL]) begin
               wa_nxt = (slot_nxt < NORM_SYNC); // R4
            end else begin
               wa_nxt = (slot_nxt < syncLen); // R3
            end
         end
         if (bclkRise && slot_r <= LAST_DATA_SLOT) begin
            rxSh_nxt = {rxSh_r[14:0], rxBit}; // R10 R14 R15
            if (slot_r == LAST_DATA_SLOT) begin
               rxWord_nxt = {rxSh_r[14:0], rxBit}; // R8
               rxEvt = 1'b1;
            end
         end
      end
   end

   // Frame engine registers.
   always_ff @(posedge clk) begin
      if (rst) begin
         bclk_r <= 1'b0;
         slot_r <= LAST_SLOT;
         wa_r <= 1'b0;
         txd_r <= 1'b0;
         txSh_r <= '0;
         rxSh_r <= '0;
         rxWord_r <= '0;
         mclk_r <= 1'b0;
      end else begin
         bclk_r <= bclk_nxt;
         slot_r <= slot_nxt;
         wa_r <= wa_nxt;
         txd_r <= txd_nxt;
         txSh_r <= txSh_nxt;
         rxSh_r <= rxSh_nxt;
         rxWord_r <= rxWord_nxt;
         mclk_r <= mclk_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pads: a disabled pin releases its drive and turns on its pull-down.
   assign txdPin = '{pullDn: ctrl_r[CB_DIS_TXD], oe: !ctrl_r[CB_DIS_TXD], out: txd_r}; // R1 R13
   assign bclkPin = '{pullDn: ctrl_r[CB_DIS_CLK], oe: !ctrl_r[CB_DIS_CLK], out: bclk_r}; // R1 R13
   assign audioWordAlignOut = '{pullDn: ctrl_r[CB_DIS_WA], oe: !ctrl_r[CB_DIS_WA], out: wa_r}; // R1 R13
   assign codecMasterClockPin = '{pullDn: ctrl_r[CB_DIS_MCLK], oe: !ctrl_r[CB_DIS_MCLK], out: mclk_r}; // R13
   assign rxdPullDn = ctrl_r[CB_DIS_RXD]; // R13

   ////////////////////////////////////////////////////////////////////////////
   // Checks on framing, data order and pins.
   a_wa_rise_slot: assert property ($rose(wa_r) |-> slot_r == FIRST_SLOT) // R3
      else $error("word align rose outside slot 0");
   a_pcm_sync_len: assert property ((portEn && !ctrl_r[CB_NORMAL] && $stable(ctrl_r) && $fell(wa_r))
      |-> slot_r == syncLen) // R3
      else $error("PCM sync pulse has the wrong length");
   a_norm_half_duty: assert property ((portEn && ctrl_r[CB_NORMAL] && $stable(ctrl_r) && $fell(wa_r))
      |-> slot_r == NORM_SYNC) // R4
      else $error("normal mode sync not high for 16 slots");
   a_frame_wrap: assert property ((bclkFall && slot_r == LAST_SLOT) |=> slot_r == FIRST_SLOT && wa_r) // R7
      else $error("frame did not wrap after 32 slots");
   a_msb_first: assert property ((bclkFall && slot_r == LAST_SLOT) |=> txd_r == $past(txData_r[15])) // R10
      else $error("first data bit is not the sample MSB");
   a_tail_zero: assert property ((portEn && slot_r > LAST_DATA_SLOT) |-> !txd_r) // R15
      else $error("data line not zero in tail slots");
   a_rx_capture: assert property ($changed(rxWord_r) |-> $past(slot_r) == LAST_DATA_SLOT && $past(bclkRise)) // R8
      else $error("received word updated outside slot 15 rise");
   a_no_sidetone: assert property ($changed(txData_r) |-> $past(doWrite)) // R11
      else $error("transmit sample changed without a bus write");
   a_master_clock: assert property (!portEn |=> !bclk_r && !wa_r) // R5
      else $error("link clock active while port is off");
   a_pin_disabled: assert property (ctrl_r[CB_DIS_WA] |-> !audioWordAlignOut.oe && audioWordAlignOut.pullDn) // R13
      else $error("disabled pin still driven");
endmodule

/* asp_codec_model.sv */
/*
 Behavioural model of the external codec on the serial audio link.
 Assumes the port launches on the falling bit clock and samples on the rising one.
*/
`timescale 1ns/1ps
module asp_codec_model
   import asp_pkg::*;
(
   // Clock and port pins
   input wire logic clk,
   input wire asp_pin_t bclk,
   input wire asp_pin_t wa,
   input wire asp_pin_t txd,
   // Word to send and line back
   input wire logic [15:0] txWord,
   output logic rxd,
   // Frame count, measurements of the last full frame, and a sticky tail flag
   output int frames,
   output int hiLen,
   output int bclkN,
   output int per,
   output logic [15:0] gotTx,
   output logic tailHigh
);
   int slot = 0;
   int hi = 0;
   int nb = 0;
   int cyc = 0;
   int last = 0;
   logic waQ = 1'b0;
   logic [15:0] sh = 16'h0000;
   initial begin
      rxd = 1'b0;
      frames = 0;
      tailHigh = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Free cycle count, used to time the frame period.
   always @(posedge clk) cyc <= cyc + 1;
   // Sample on the rising edge, MSB first in the first sixteen slots.
   always @(posedge bclk.out) begin
      nb++;
      if (wa.out) hi++;
      if (slot < 16) sh = {sh[14:0], txd.out};
      else if (txd.out !== 1'b0) tailHigh = 1'b1;
      // Level at the last rise, so a stale value from a cut frame never hides the next start.
      waQ = wa.out;
   end
   // Word-align high at a fall but low at the rise before opens slot 0 of a new frame.
   // A short settle lets word-align and data launched on the same edge reach their pins first.
   always @(negedge bclk.out) begin
      #1;
      if (wa.out && !waQ) begin
         if (frames > 0) begin
            per = cyc - last;
            hiLen = hi;
            bclkN = nb;
            gotTx = sh;
         end
         last = cyc;
         frames++;
         slot = 0;
         hi = 0;
         nb = 0;
      end else slot++;
      // Outside the word the line toggles so a stale level can never pass.
      rxd = (slot < 16) ? txWord[15 - slot] : ~rxd;
   end
endmodule

/* asp_master_port_tb.sv */
/*
 Self-checking bench for the serial audio master port.
 Assumes the codec model on the link and an AXI4-Lite master in this module.
*/
`timescale 1ns/1ps
module asp_master_port_tb
   import asp_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid, rxd, rxdPullDn, tailHigh, mq;
   logic [1:0] bresp, rresp, r;
   logic [31:0] rdata, d, v, cfg;
   logic [15:0] codecWord = 16'h0000;
   logic [15:0] gotTx, txw;
   asp_pin_t txdPin, bclkPin, waPin, mclkPin;
   int mismatches = 0, n_checks = 0, seed = 70, frames, hiLen, bclkN, per, f0, n, rate;
   logic [31:0] cfgs [3] = '{32'h0000_0011, 32'h0000_000d, 32'h0000_0037};
   always #4 clk = ~clk;
   asp_master_port asp_master_port_i (.clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .txdPin(txdPin), .bclkPin(bclkPin),
      .audioWordAlignOut(waPin), .codecMasterClockPin(mclkPin), .rxdIn(rxd), .rxdPullDn(rxdPullDn));
   asp_codec_model asp_codec_model_i (.clk(clk), .bclk(bclkPin), .wa(waPin), .txd(txdPin),
      .txWord(codecWord), .rxd(rxd), .frames(frames), .hiLen(hiLen), .bclkN(bclkN), .per(per),
      .gotTx(gotTx), .tailHigh(tailHigh));
   ////////////////////////////////////////////////////////////////////////////////
   // Expected sync length, sample rate and master-clock edges per 1250 cycles.
   function automatic int sync_len(logic [31:0] c);
      return c[CB_NORMAL] ? 16 : (c[CB_SYNC2] ? 2 : 1);
   endfunction
   function automatic int rate_of(logic [31:0] c);
      return c[CB_RATE16] ? RATE_16K_HZ : RATE_8K_HZ;
   endfunction
   function automatic int mclk_edges(logic [31:0] c);
      return (c[CB_MCLK26] ? MCLK_26_HZ : MCLK_13_HZ) / 100_000;
   endfunction
   // Counts a comparison and reports a mismatch at once.
   task automatic chk(input logic ok, input string m);
      n_checks++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("BAD %0t %s", $time, m);
      end
   endtask
   // Write: ready is judged mid-cycle so the taking edge is never raced.
   task automatic wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] rs);
      logic aT, wT, bT;
      @(posedge clk);
      awaddr <= a;
      wdata <= dat;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      bT = 1'b0;
      while (!bT) begin
         @(negedge clk);
         aT = awvalid & awready;
         wT = wvalid & wready;
         bT = (bvalid === 1'b1);
         rs = bresp;
         @(posedge clk);
         if (aT) awvalid <= 1'b0;
         if (wT) wvalid <= 1'b0;
      end
      bready <= 1'b0;
   endtask
   // Read with the same mid-cycle judging of handshakes.
   task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] rs);
      logic aT, rT;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      rT = 1'b0;
      while (!rT) begin
         @(negedge clk);
         aT = arvalid & arready;
         rT = (rvalid === 1'b1);
         dat = rdata;
         rs = rresp;
         @(posedge clk);
         if (aT) arvalid <= 1'b0;
      end
      rready <= 1'b0;
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence: registers, disabled pins, then each framing mode.
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rd(OFF_CTRL, d, r);
      chk(d === CTRL_RST && r === RESP_OKAY, "control reset value");
      chk(txdPin.oe === 1'b1 && txdPin.pullDn === 1'b0, "pin reset state");
      v = $random(seed);
      wr(OFF_CTRL, v, r);
      rd(OFF_CTRL, d, r);
      chk(d === (v & CTRL_MASK), "control read back");
      wr(OFF_CTRL, 32'h0000_1f00, r);
      repeat (3) @(posedge clk);
      chk({txdPin.oe, bclkPin.oe, waPin.oe, mclkPin.oe} === 4'h0, "disabled drive");
      chk({txdPin.pullDn, bclkPin.pullDn, waPin.pullDn, mclkPin.pullDn, rxdPullDn} === 5'h1f, "pull");
      wr(8'h10, v, r);
      chk(r === RESP_SLVERR, "unmapped write");
      rd(8'h10, d, r);
      chk(r === RESP_SLVERR && d === 32'h0, "unmapped read");
      $display("test registers done");
      for (int i = 0; i < 3; i++) begin
         cfg = cfgs[i];
         rate = rate_of(cfg);
         txw = (i == 0) ? 16'h8001 : 16'($random(seed));
         codecWord <= (i == 0) ? 16'h7ffe : 16'($random(seed));
         wr(OFF_TXDATA, {16'h0, txw}, r);
         wr(OFF_CTRL, cfg, r);
         f0 = frames;
         if (cfg[CB_MCLK_EN]) begin
            n = 0;
            mq = 1'b0;
            repeat (1250) begin
               @(negedge clk);
               if (mclkPin.out && !mq) n++;
               mq = mclkPin.out;
            end
            chk(n >= mclk_edges(cfg) - 2 && n <= mclk_edges(cfg) + 2, "master clock rate");
         end
         while (frames < f0 + 2) @(posedge clk);
         chk(hiLen == sync_len(cfg), "sync length");
         chk(bclkN == FRAME_SLOTS, "bit clocks per frame");
         chk(per >= CLK_HZ / rate - 2 && per <= CLK_HZ / rate + 2, "frame period");
         chk(gotTx === txw, "sent word");
         rd(OFF_RXDATA, d, r);
         chk(d === {{16{codecWord[15]}}, codecWord}, "received word");
         wr(OFF_CTRL, 32'h0, r);
         $display("test mode %0d done", i);
      end
      rd(OFF_STATUS, d, r);
      chk(d[SB_RXNEW] === 1'b1 && d[SB_TXTAKEN] === 1'b1, "status flags set");
      wr(OFF_STATUS, 32'h3, r);
      rd(OFF_STATUS, d, r);
      chk(d[1:0] === 2'b00, "status flags cleared");
      chk(tailHigh === 1'b0, "idle slots low");
      $display("test status done");
      complete_run();
   end
   // Watchdog sized above the longest expected run of about 32000 cycles.
   initial begin
      #(90_000 * 8);
      mismatches++;
      $display("BAD %0t timeout", $time);
      complete_run();
   end
endmodule
